// >>> hru_top.sv
// Notes on behaviour
// - Neutral mode refreshes only harmonic rms registers unless first index is one
// - Fundamental rms continuous in phase mode only
// - Neutral distortion computed when first index is one
// - First index one loads unity distortion value
// - Engine runs on 8 kHz processing tick
// - Rate field picks result refresh period
// - Rate code seven stops harmonic calculation
// - Ready flag after settling, then every update
// - Settling field selects first ready delay
// - Ready mode flags every update immediately
// - Masked ready drives interrupt low; write-one clears
// - Pin select chooses ready pulse or energy pulse
// - Ready pin idles high, pulses low 10 us
// - Burst port walks harmonic results in sequence
// - Waveform samples stored each tick, 24 bits
// - Sample ready flag bit 17, maskable
// - Samples read sign-extended to 32 bits
// - Distortion ratios saturate at format maximum
//
// The placing of the registers and strobed register access were decided locally.
module hru_top
  import hru_pkg::*;
(
  input  wire logic             CLK_SYS,
  input  wire logic             RESETN,
  input  wire logic             CE,
  input  wire logic [7:0]       ADDR,
  input  wire logic [31:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [31:0]      RDATA,
  input  wire logic             TICK_8K,
  input  wire logic             NEUTRAL_MODE,
  input  wire logic [7:0][23:0] ENG_RMS,
  input  wire logic [5:0][31:0] ENG_DIST,
  input  wire logic             SAMPLE_WE,
  input  wire logic [3:0]       SAMPLE_IDX,
  input  wire logic [23:0]      SAMPLE_DATA,
  input  wire logic             SECOND_PULSE_OUTPUT,
  output logic                  PULSE_PIN,
  output logic                  IRQ_N,
  output logic                  CALC_EN
);
  // Whole block state
  typedef struct packed {
    logic [7:0]        hcfg;       // Rate, settling, ready mode
    logic              psel;       // Ready pin select
    logic [2:0][5:0]   idx;        // Harmonic indices
    logic              hrdy;       // Harmonic ready flag
    logic              srdy;       // Sample ready flag
    logic [1:0]        mask;       // {harmonic, sample} masks
    logic [13:0][23:0] res;        // Result registers
    logic [12:0]       rate_cnt;   // Ticks within update period
    logic [13:0]       setl_cnt;   // Ticks since start
    logic              settled;    // Settling delay elapsed
    logic              upd;        // Results refreshed last edge
    logic [9:0]        pcnt;       // Ready pulse remaining cycles
    logic              pin;        // Shared pin level
    logic              irq_n;      // Interrupt level
    logic              calc_en;    // Engine enabled
    logic [31:0]       rdata;      // Register read data
    logic              rd_mem;     // Read data from sample memory
    logic [3:0]        bptr;       // Burst position
  } hru_st_t;

  hru_st_t   st_ff;
  hru_st_t   nxt_st;
  hru_mem_if mem_if ();

  // Clamp a wide signed ratio into the 3.21 signed word
  function automatic hru_word_t sat24(input logic signed [31:0] v);
    if (v > $signed({8'h00, HRU_SAT_MAX}))
      return HRU_SAT_MAX;
    else if (v < $signed({8'hff, HRU_SAT_MIN}))
      return HRU_SAT_MIN;
    else
      return v[23:0];
  endfunction

  // Last tick count of an update period; the full 8192 would not fit 13 bits
  function automatic logic [12:0] rate_ticks(input logic [2:0] code);
    return 13'((RATE_US[code] / TICK_US) - 1);
  endfunction

  // Settling delay in processing ticks
  function automatic logic [13:0] setl_ticks(input logic [1:0] code);
    return 14'((SETL_MS[code] * 1000) / TICK_US);
  endfunction

  // Sample memory, written straight from the engine
  hru_wave_mem u_mem (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .ce    (CE),
    .port  (mem_if.host)
  );

  assign mem_if.we    = SAMPLE_WE;
  assign mem_if.waddr = SAMPLE_IDX;
  assign mem_if.wdata = SAMPLE_DATA;
  assign mem_if.raddr = ADDR[5:2];
  assign mem_if.re    = RD && ADDR[7:6] == HRU_OFF_WAVE[7:6];

  // Next-state logic
  always_comb
  begin
    logic [2:0] rate;
    logic       calc_on;
    logic       restart;
    logic       upd;
    logic       setl_done;
    logic       hset;
    logic [3:0] k;
    rate      = st_ff.hcfg[HRU_RATE_LSB +: 3];
    calc_on   = rate != HRU_RATE_OFF;
    restart   = WR && (ADDR == HRU_OFF_HCFG || ADDR == HRU_OFF_IDX1
                || ADDR == HRU_OFF_IDX2 || ADDR == HRU_OFF_IDX3);
    upd       = 1'b0;
    setl_done = 1'b0;
    hset      = 1'b0;
    k         = 4'(ADDR[5:2] - 4'h8);
    nxt_st    = st_ff;
    nxt_st.rd_mem = 1'b0;
    // Register writes
    if (WR)
    begin
      case (ADDR)
        HRU_OFF_HCFG:  nxt_st.hcfg = WDATA[7:0];
        HRU_OFF_CFG:   nxt_st.psel = WDATA[HRU_PSEL_BIT];
        HRU_OFF_IDX1:  nxt_st.idx[0] = WDATA[5:0];
        HRU_OFF_IDX2:  nxt_st.idx[1] = WDATA[5:0];
        HRU_OFF_IDX3:  nxt_st.idx[2] = WDATA[5:0];
        HRU_OFF_MASK:  nxt_st.mask = {WDATA[HRU_HRDY_BIT], WDATA[HRU_SRDY_BIT]};
        HRU_OFF_BURST: nxt_st.bptr = 4'h0;
        // Write-one clears; a zero leaves the flag alone
        HRU_OFF_STAT:
        begin
          if (WDATA[HRU_HRDY_BIT])
            nxt_st.hrdy = 1'b0;
          if (WDATA[HRU_SRDY_BIT])
            nxt_st.srdy = 1'b0;
        end
        default: ;
      endcase
    end
    // Update scheduler on the processing tick
    if (!calc_on || restart)
    begin
      nxt_st.rate_cnt = '0;
      nxt_st.setl_cnt = '0;
      nxt_st.settled  = 1'b0;
    end
    else if (TICK_8K)
    begin
      if (st_ff.rate_cnt >= rate_ticks(rate))
      begin
        upd             = 1'b1;
        nxt_st.rate_cnt = '0;
      end
      else
        nxt_st.rate_cnt = st_ff.rate_cnt + 13'h1;
      if (!st_ff.settled)
      begin
        if (st_ff.setl_cnt >= setl_ticks(st_ff.hcfg[HRU_SETL_LSB +: 2]) - 14'h1)
        begin
          setl_done      = 1'b1;
          nxt_st.settled = 1'b1;
        end
        else
          nxt_st.setl_cnt = st_ff.setl_cnt + 14'h1;
      end
    end
    // Fundamental rms only tracked while a phase is analysed
    if (calc_on && TICK_8K && !NEUTRAL_MODE)
    begin
      nxt_st.res[0] = ENG_RMS[0];
      nxt_st.res[1] = ENG_RMS[1];
    end
    // Refresh of harmonic result registers
    if (upd)
    begin
      for (int i = 2; i < 8; i++)
        nxt_st.res[i] = ENG_RMS[i];
      if (!NEUTRAL_MODE || st_ff.idx[0] == HRU_IDX_FUND)
      begin
        for (int i = 0; i < 6; i++)
          nxt_st.res[8 + i] = sat24(ENG_DIST[i]);
        if (st_ff.idx[0] == HRU_IDX_FUND)
        begin
          nxt_st.res[8] = HRU_UNITY;
          nxt_st.res[9] = HRU_UNITY;
        end
      end
    end
    // Ready flag: set wins over a same-cycle clear
    hset = (upd && (st_ff.hcfg[HRU_MODE_BIT] || st_ff.settled))
           || (setl_done && !st_ff.hcfg[HRU_MODE_BIT]);
    if (hset)
      nxt_st.hrdy = 1'b1;
    if (TICK_8K)
      nxt_st.srdy = 1'b1;
    nxt_st.upd     = upd;
    nxt_st.calc_en = calc_on;
    // Pin pulse timing
    if (upd)
      nxt_st.pcnt = 10'(PULSE_CYC);
    else if (st_ff.pcnt != 10'h0)
      nxt_st.pcnt = st_ff.pcnt - 10'h1;
    // New select and mask act at once, so pin and interrupt never lag a write
    nxt_st.pin   = nxt_st.psel ? (nxt_st.pcnt == 10'h0) : SECOND_PULSE_OUTPUT;
    nxt_st.irq_n = !(|({nxt_st.hrdy, nxt_st.srdy} & nxt_st.mask));
    // Register reads, answered next cycle
    if (RD)
    begin
      nxt_st.rdata = 32'h0;
      if (ADDR[7:6] == HRU_OFF_WAVE[7:6])
        nxt_st.rd_mem = ADDR[5:2] < HRU_NWAVE && ADDR[1:0] == 2'h0;
      else if (ADDR >= HRU_OFF_RES && ADDR <= HRU_OFF_RESEND && ADDR[1:0] == 2'h0)
        nxt_st.rdata = {8'h00, st_ff.res[k]};
      else
      begin
        case (ADDR)
          HRU_OFF_HCFG:  nxt_st.rdata = {24'h0, st_ff.hcfg};
          HRU_OFF_CFG:   nxt_st.rdata = 32'(st_ff.psel) << HRU_PSEL_BIT;
          HRU_OFF_IDX1:  nxt_st.rdata = {26'h0, st_ff.idx[0]};
          HRU_OFF_IDX2:  nxt_st.rdata = {26'h0, st_ff.idx[1]};
          HRU_OFF_IDX3:  nxt_st.rdata = {26'h0, st_ff.idx[2]};
          HRU_OFF_STAT:  nxt_st.rdata = (32'(st_ff.hrdy) << HRU_HRDY_BIT)
                                      | (32'(st_ff.srdy) << HRU_SRDY_BIT);
          HRU_OFF_MASK:  nxt_st.rdata = (32'(st_ff.mask[1]) << HRU_HRDY_BIT)
                                      | (32'(st_ff.mask[0]) << HRU_SRDY_BIT);
          // Burst port steps through all results and wraps
          HRU_OFF_BURST:
          begin
            nxt_st.rdata = {8'h00, st_ff.res[st_ff.bptr]};
            nxt_st.bptr  = (st_ff.bptr == HRU_NRES - 4'h1) ? 4'h0 : st_ff.bptr + 4'h1;
          end
          default: nxt_st.rdata = 32'h0;
        endcase
      end
    end
  end

  // State register, frozen while CE low
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      st_ff       <= '0;
      st_ff.hcfg  <= HRU_HCFG_RST;
      st_ff.pin   <= 1'b1;
      st_ff.irq_n <= 1'b1;
    end
    else if (CE)
      st_ff <= nxt_st;
  end

  // Samples leave sign-extended to a full word
  assign RDATA     = st_ff.rd_mem ? {{8{mem_if.rdata[23]}}, mem_if.rdata}
                                  : st_ff.rdata;
  assign PULSE_PIN = st_ff.pin;
  assign IRQ_N     = st_ff.irq_n;
  assign CALC_EN   = st_ff.calc_en;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  property p_w1c;
    CE && WR && ADDR == HRU_OFF_STAT && WDATA[HRU_HRDY_BIT] && !nxt_st.upd
      && !(st_ff.hcfg[HRU_MODE_BIT] == 1'b0 && nxt_st.settled && !st_ff.settled)
      |=> !st_ff.hrdy;
  endproperty
  a_w1c: assert property (p_w1c) else $error("ready flag not cleared");

  property p_irq;
    (|({st_ff.hrdy, st_ff.srdy} & st_ff.mask)) |-> !IRQ_N;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not low");

  property p_off;
    st_ff.hcfg[HRU_RATE_LSB +: 3] == HRU_RATE_OFF && CE |=> !st_ff.upd && !CALC_EN;
  endproperty
  a_off: assert property (p_off) else $error("update while disabled");

  property p_pin;
    st_ff.upd && st_ff.psel |-> !PULSE_PIN;
  endproperty
  a_pin: assert property (p_pin) else $error("ready pin not low");

  property p_unity;
    st_ff.upd && st_ff.idx[0] == HRU_IDX_FUND |-> st_ff.res[8] == HRU_UNITY;
  endproperty
  a_unity: assert property (p_unity) else $error("unity not loaded");

  property p_sat;
    CE && nxt_st.upd && (!NEUTRAL_MODE || st_ff.idx[0] == HRU_IDX_FUND)
      && $signed(ENG_DIST[2]) > 32'sh7fffff
      |=> st_ff.res[10] == HRU_SAT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("ratio not clamped");

  property p_nfund;
    CE && NEUTRAL_MODE |=> $stable(st_ff.res[0]) && $stable(st_ff.res[1]);
  endproperty
  a_nfund: assert property (p_nfund) else $error("fundamental moved");

  property p_ndist;
    CE && NEUTRAL_MODE && st_ff.idx[0] != HRU_IDX_FUND |=> $stable(st_ff.res[12]);
  endproperty
  a_ndist: assert property (p_ndist) else $error("distortion moved");

  property p_srdy;
    CE && TICK_8K |=> st_ff.srdy;
  endproperty
  a_srdy: assert property (p_srdy) else $error("sample flag not set");

  property p_settle;
    st_ff.upd && !st_ff.hcfg[HRU_MODE_BIT] && !$past(st_ff.settled, 2)
      && !st_ff.settled |-> !$rose(st_ff.hrdy);
  endproperty
  a_settle: assert property (p_settle) else $error("early ready flag");
endmodule

// >>> hru_pkg.sv
package hru_pkg;
  // Register byte offsets
  localparam logic [7:0] HRU_OFF_HCFG   = 8'h00;
  localparam logic [7:0] HRU_OFF_CFG    = 8'h04;
  localparam logic [7:0] HRU_OFF_IDX1   = 8'h08;
  localparam logic [7:0] HRU_OFF_IDX2   = 8'h0c;
  localparam logic [7:0] HRU_OFF_IDX3   = 8'h10;
  localparam logic [7:0] HRU_OFF_STAT   = 8'h14;
  localparam logic [7:0] HRU_OFF_MASK   = 8'h18;
  localparam logic [7:0] HRU_OFF_RES    = 8'h20;
  localparam logic [7:0] HRU_OFF_RESEND = 8'h54;
  localparam logic [7:0] HRU_OFF_BURST  = 8'h58;
  localparam logic [7:0] HRU_OFF_WAVE   = 8'h80;
  // Field positions
  localparam int HRU_RATE_LSB   = 5;
  localparam int HRU_SETL_LSB   = 3;
  localparam int HRU_MODE_BIT   = 0;
  localparam int HRU_PSEL_BIT   = 2;
  localparam int HRU_HRDY_BIT   = 19;
  localparam int HRU_SRDY_BIT   = 17;
  // Reset values and codes
  localparam logic [7:0]  HRU_HCFG_RST  = 8'h08;
  localparam logic [2:0]  HRU_RATE_OFF  = 3'h7;
  localparam logic [5:0]  HRU_IDX_FUND  = 6'h01;
  localparam logic [23:0] HRU_UNITY     = 24'h1fffff;
  localparam logic [23:0] HRU_SAT_MAX   = 24'h7fffff;
  localparam logic [23:0] HRU_SAT_MIN   = 24'h800000;
  localparam logic [3:0]  HRU_NRES      = 4'he;
  localparam logic [3:0]  HRU_NWAVE     = 4'hd;
  // Timing: processing tick, update periods, settling times, pin pulse
  localparam int CLK_NS       = 20;
  localparam int TICK_US      = 125;
  localparam int RATE_US [7]  = '{125, 250, 1000, 16000, 128000, 512000, 1024000};
  localparam int SETL_MS [4]  = '{500, 750, 1000, 1250};
  localparam int PULSE_NS     = 10000;
  localparam int PULSE_CYC    = PULSE_NS / CLK_NS;
  typedef logic [23:0] hru_word_t;
endpackage

// >>> hru_mem_if.sv
interface hru_mem_if;
  logic            we;     // Sample store strobe
  logic [3:0]      waddr;  // Sample slot written
  logic [23:0]     wdata;  // Sample value
  logic            re;     // Read strobe
  logic [3:0]      raddr;  // Sample slot read
  logic [23:0]     rdata;  // Registered read data
  modport host (output we, waddr, wdata, re, raddr, input rdata);
  modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// >>> hru_wave_mem.sv
module hru_wave_mem
  import hru_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  hru_mem_if.mem    port
);
  // Whole memory state
  typedef struct packed {
    logic [12:0][23:0] words;
    logic [23:0]       rdata;
  } hru_mem_st_t;

  hru_mem_st_t st_ff;
  hru_mem_st_t nxt_st;

  // Store on write, register read word
  always_comb
  begin
    nxt_st = st_ff;
    if (port.we && port.waddr < HRU_NWAVE)
    begin
      nxt_st.words[port.waddr] = port.wdata;
    end
    if (port.re && port.raddr < HRU_NWAVE)
    begin
      nxt_st.rdata = st_ff.words[port.raddr];
    end
  end

  // State register, frozen while ce low
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else if (ce)
      st_ff <= nxt_st;
  end

  assign port.rdata = st_ff.rdata;
endmodule

// >>> hru_mcu_model.sv
module hru_mcu_model
  import hru_pkg::*;
(
  input  wire logic        clk,    // System clock
  output logic      [7:0]  addr,   // Register address
  output logic      [31:0] wdata,  // Write data
  output logic             wr,     // Write strobe
  output logic             rd,     // Read strobe
  input  wire logic [31:0] rdata   // Read data, cycle after rd only
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus from time zero
  initial
  begin
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // One-cycle write; a gap cycle follows so strobes never merge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // Read; data only valid in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  // Index values are six bits, never above 63
  task automatic set_idx(input int n, input logic [5:0] h);
    wr_reg(HRU_OFF_IDX1 + 8'(4 * n), {26'h0, h});
  endtask
  // Pin select, then indices, then harmonic setup
  task automatic setup(input logic psel, input logic [5:0] h1, input logic [7:0] hcfg);
    wr_reg(HRU_OFF_CFG, {29'h0, psel, 2'h0});
    set_idx(0, h1);
    set_idx(1, 6'h02);
    set_idx(2, 6'h03);
    wr_reg(HRU_OFF_HCFG, {24'h0, hcfg});
  endtask
endmodule

// >>> test_harmonic_result_update_ready.sv
module test_harmonic_result_update_ready
  import hru_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk_sys  = 1'b0;     // 50 MHz
  logic             resetn   = 1'b0;     // Active-low reset
  logic [7:0]       addr;                // Bus from the model
  logic [31:0]      wdata;
  logic             bus_wr;
  logic             bus_rd;
  logic [31:0]      rdata;
  logic             tick     = 1'b0;     // Fast tick stand-in
  logic             neutral  = 1'b0;     // Analysis mode
  logic [7:0][23:0] eng_rms  = '0;       // Engine rms
  logic [5:0][31:0] eng_dist = '0;       // Engine ratios
  logic             s_we     = 1'b0;     // Sample store
  logic [3:0]       s_idx    = 4'h0;
  logic [23:0]      s_data   = 24'h0;
  logic             second_pulse_output = 1'b1; // Energy pulse
  logic             pin;
  logic             irq_n;
  logic             calc_en;
  logic [31:0]      lfsr     = 32'hf076; // Random state
  logic [31:0]      d;                   // Last read word
  logic [31:0]      keep [14];           // Saved results
  int               per [8]  = '{1, 2, 8, 128, 1024, 4096, 8192, 4}; // Ticks per update
  int               fails    = 0;
  int               samples_checked = 0;
  // Clock
  always #10 clk_sys = ~clk_sys;
  hru_top i_dut (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(bus_wr), .RD(bus_rd), .RDATA(rdata), .TICK_8K(tick),
    .NEUTRAL_MODE(neutral), .ENG_RMS(eng_rms), .ENG_DIST(eng_dist),
    .SAMPLE_WE(s_we), .SAMPLE_IDX(s_idx), .SAMPLE_DATA(s_data),
    .SECOND_PULSE_OUTPUT(second_pulse_output), .PULSE_PIN(pin), .IRQ_N(irq_n),
    .CALC_EN(calc_en));
  hru_mcu_model i_mcu (.clk(clk_sys), .addr(addr), .wdata(wdata), .wr(bus_wr),
    .rd(bus_rd), .rdata(rdata));
  // Shift register, taps 32 22 2 1
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict
  task automatic finish_test();
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Ticks two cycles apart, far faster than real time
  task automatic tick_n(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
    end
  endtask
  task automatic get(input logic [7:0] a);
    i_mcu.rd_reg(a, d);
  endtask
  // Fresh random engine rms
  task automatic new_eng();
    for (int k = 0; k < 8; k++)
    begin
      lfsr = nxt_rand(lfsr);
      eng_rms[k] <= lfsr[23:0];
    end
  endtask
  // Hang guard
  initial
  begin
    repeat (95000) @(posedge clk_sys);
    fails++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1 check({29'h0, pin, irq_n, calc_en}, 32'h6);
    @(posedge clk_sys);
    resetn <= 1'b1;
    get(HRU_OFF_HCFG);
    check(d, 32'h8);
    get(HRU_OFF_STAT);
    check(d, 32'h0);
    // Immediate mode, pulse on pin, both flags masked in
    i_mcu.setup(1'b1, 6'h05, 8'h01);
    i_mcu.wr_reg(HRU_OFF_MASK, 32'h000a0000);
    new_eng();
    second_pulse_output <= 1'b0;
    tick_n(1);
    #1 check({31'h0, pin}, 32'h0);
    repeat (498) @(posedge clk_sys);
    #1 check({31'h0, pin}, 32'h0);
    repeat (3) @(posedge clk_sys);
    #1 check({31'h0, pin}, 32'h1);
    get(HRU_OFF_STAT);
    check(d & 32'h000a0000, 32'h000a0000);
    check({31'h0, irq_n}, 32'h0);
    i_mcu.wr_reg(HRU_OFF_STAT, 32'h00020000);
    get(HRU_OFF_STAT);
    check(d & 32'h000a0000, 32'h00080000);
    check({31'h0, irq_n}, 32'h0);
    i_mcu.wr_reg(HRU_OFF_STAT, 32'h00080000);
    get(HRU_OFF_STAT);
    check(d & 32'h000a0000, 32'h0);
    check({31'h0, irq_n}, 32'h1);
    // Results, then the same words through the burst port
    for (int k = 0; k < 14; k++)
    begin
      get(HRU_OFF_RES + 8'(4 * k));
      keep[k] = d;
      if (k < 8)
        check({8'h0, d[23:0]}, {8'h0, eng_rms[k]});
    end
    i_mcu.wr_reg(HRU_OFF_BURST, 32'h0);
    for (int k = 0; k < 14; k++)
    begin
      get(HRU_OFF_BURST);
      check(d, keep[k]);
    end
    // Energy pulse passes when the ready pulse is deselected
    i_mcu.wr_reg(HRU_OFF_CFG, 32'h0);
    i_mcu.wr_reg(HRU_OFF_MASK, 32'h0);
    for (int v = 0; v < 2; v++)
    begin
      second_pulse_output <= v[0];
      repeat (3) @(posedge clk_sys);
      #1 check({31'h0, pin}, {31'h0, v[0]});
    end
    // Every rate code; results hold between updates
    for (int r = 0; r < 8; r++)
    begin
      i_mcu.wr_reg(HRU_OFF_HCFG, {24'h0, r[2:0], 5'h01});
      i_mcu.wr_reg(HRU_OFF_STAT, 32'h00080000);
      new_eng();
      tick_n(per[r] - 1);
      get(HRU_OFF_RES + 8'h08);
      check({8'h0, d[23:0]}, {8'h0, keep[2][23:0]});
      get(HRU_OFF_STAT);
      check(d & 32'h00080000, 32'h0);
      tick_n(1);
      get(HRU_OFF_STAT);
      check(d & 32'h00080000, (r < 7) ? 32'h00080000 : 32'h0);
      check({31'h0, calc_en}, {31'h0, r < 7});
      check({31'h0, irq_n}, 32'h1);
      if (r < 7)
        keep[2] = {8'h0, eng_rms[2]};
      get(HRU_OFF_RES + 8'h08);
      check({8'h0, d[23:0]}, {8'h0, keep[2][23:0]});
    end
    // Every settling code in settled mode, then the next update
    for (int s = 0; s < 4; s++)
    begin
      i_mcu.wr_reg(HRU_OFF_HCFG, {24'h0, 3'h0, s[1:0], 3'h0});
      i_mcu.wr_reg(HRU_OFF_STAT, 32'h00080000);
      tick_n(3999 + 2000 * s);
      get(HRU_OFF_STAT);
      check(d & 32'h00080000, 32'h0);
      tick_n(1);
      get(HRU_OFF_STAT);
      check(d & 32'h00080000, 32'h00080000);
      i_mcu.wr_reg(HRU_OFF_STAT, 32'h00080000);
      tick_n(1);
      get(HRU_OFF_STAT);
      check(d & 32'h00080000, 32'h00080000);
    end
    // Neutral analysis: fundamentals frozen, distortion only with index one
    i_mcu.wr_reg(HRU_OFF_HCFG, 32'h1);
    neutral <= 1'b1;
    get(HRU_OFF_RES);
    keep[0] = d;
    new_eng();
    lfsr = nxt_rand(lfsr);
    eng_dist[2] <= 32'h01000000;
    eng_dist[3] <= {11'h0, lfsr[20:0]};
    tick_n(1);
    get(HRU_OFF_RES);
    check(d, keep[0]);
    get(HRU_OFF_RES + 8'h08);
    check({8'h0, d[23:0]}, {8'h0, eng_rms[2]});
    get(HRU_OFF_RES + 8'h28);
    check({8'h0, d[23:0]}, {8'h0, keep[10][23:0]});
    i_mcu.set_idx(0, 6'h01);
    tick_n(1);
    for (int k = 0; k < 4; k++)
    begin
      get(HRU_OFF_RES + 8'h20 + 8'(4 * k));
      keep[k] = (k < 2) ? 32'h1fffff : ((k == 2) ? 32'h7fffff : {8'h0, eng_dist[3][23:0]});
      check({8'h0, d[23:0]}, keep[k]);
    end
    // Waveform slots, sign-extended on read
    for (int i = 0; i < 13; i++)
    begin
      lfsr = nxt_rand(lfsr);
      @(posedge clk_sys);
      s_we   <= 1'b1;
      s_idx  <= i[3:0];
      s_data <= lfsr[23:0];
      @(posedge clk_sys);
      s_we   <= 1'b0;
      get(HRU_OFF_WAVE + 8'(4 * i));
      check(d, {{8{lfsr[23]}}, lfsr[23:0]});
    end
    finish_test();
  end
endmodule
